//--- src/lsfac_pkg.sv
/*
  constants, types and timing counts for the led sink fault/adapt controller.
  assumes a 20 MHz clock; all timing counts derive from it.
*/
package lsfac_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int CLK_NS = NS_PER_S / CLK_HZ;
  localparam int NUM_SINKS = 3;
  // times in ns
  localparam longint FILT_NS = 1_000;
  localparam longint CLR_MIN_NS = 2_000;
  localparam longint CLR_MAX_NS = 20_000;
  localparam longint SHORT_FILT_NS = 100_000;
  localparam longint OVP_LONG_NS = 560_000_000;
  localparam longint OVP_SHORT_NS = 50_000_000;
  localparam longint OVP_RESTORE_NS = 160_000_000;
  localparam longint RECOVER_NS = 100_000_000;
  localparam longint SENSE_NS = 10_000;
  localparam longint NUDGE_NS = 100_000;
  localparam longint STEP_NS = 10_000;
  // least times round up
  localparam int FILT_CYC = int'((FILT_NS + CLK_NS - 1) / CLK_NS);
  localparam int CLR_MIN_CYC = int'((CLR_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int CLR_MAX_CYC = int'(CLR_MAX_NS / CLK_NS);
  localparam int SHORT_FILT_CYC = int'((SHORT_FILT_NS + CLK_NS - 1) / CLK_NS);
  localparam int OVP_LONG_CYC = int'((OVP_LONG_NS + CLK_NS - 1) / CLK_NS);
  localparam int OVP_SHORT_CYC = int'((OVP_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam int OVP_RESTORE_CYC = int'((OVP_RESTORE_NS + CLK_NS - 1) / CLK_NS);
  localparam int RECOVER_CYC = int'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
  localparam int SENSE_CYC = int'((SENSE_NS + CLK_NS - 1) / CLK_NS);
  localparam int NUDGE_CYC = int'((NUDGE_NS + CLK_NS - 1) / CLK_NS);
  localparam int STEP_CYC = int'((STEP_NS + CLK_NS - 1) / CLK_NS);
  // adaptive target code
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam logic [7:0] CODE_INIT = 8'hE1;

  typedef enum logic [2:0] {
    LSFAC_STANDBY = 3'b000,
    LSFAC_SENSE   = 3'b001,
    LSFAC_ACTIVE  = 3'b011,
    LSFAC_RECOVER = 3'b010
  } lsfac_state_e;

  // raw headroom flags for one sink
  typedef struct packed {
    logic aboveHigh;
    logic aboveMid;
    logic aboveLow;
  } lsfac_head_s;

  // analog protection flags
  typedef struct packed {
    logic outOver;
    logic inOver;
    logic inUnder;
    logic thermHot;
    logic thermClear;
  } lsfac_prot_s;
endpackage : lsfac_pkg

//--- src/lsfac_top.sv
/*
  led sink fault and adaptive target controller, single clock.
  assumes synchronous inputs from the analog section and a 20 MHz clock.
*/
`timescale 1ns/10ps
module lsfac_top #(
  parameter int OVP_LONG    = lsfac_pkg::OVP_LONG_CYC,
  parameter int OVP_SHORT   = lsfac_pkg::OVP_SHORT_CYC,
  parameter int OVP_RESTORE = lsfac_pkg::OVP_RESTORE_CYC,
  parameter int RECOVER     = lsfac_pkg::RECOVER_CYC,
  parameter int NUDGE       = lsfac_pkg::NUDGE_CYC,
  parameter int STEP        = lsfac_pkg::STEP_CYC
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // host side
  input  wire logic                 enableSupplyInput,
  input  wire logic                 pwmIn,
  // analog flags
  input  wire logic [2:0]           sinkGrounded,
  input  wire lsfac_pkg::lsfac_head_s [2:0] headRaw,
  input  wire lsfac_pkg::lsfac_prot_s       protRaw,
  // outputs
  output logic [2:0]                sinkEnable,
  output logic                      converterEnable,
  output logic [7:0]                targetCode,
  output logic                      faultOut,
  output logic                      faultOe,
  output logic [2:0]                openStringFault,
  output logic [2:0]                shortedStringFault,
  output logic                      inputOvervoltageFault,
  output logic                      inputUndervoltageFault,
  output logic                      thermalShutdownFault
);
  import lsfac_pkg::*;

  lsfac_state_e state_r;
  logic [2:0]   excluded_r;
  logic [2:0]   lowF_r, midF_r, highF_r;
  logic [2:0]   lowOk, midOk, highOk;
  logic [31:0]  stCnt_r;
  logic [15:0]  enLowCnt_r;
  logic         enPrev_r;
  logic [31:0]  stepCnt_r;
  logic [31:0]  nudgeCnt_r;
  logic [31:0]  ovoCnt_r, oviCnt_r, uvCnt_r;
  logic [31:0]  activeCnt_r;
  logic         ovpShort_r;
  logic [2:0]   usable, openNew, shortNew;
  logic         anyLow, allMid, inWindow, protFault, clrPulse, longLow;

  // headroom filters, one per flag
  genvar g;
  generate
    for (g = 0; g < NUM_SINKS; g++) begin : gFilt
      lsfac_filt uLow (.clk(clk), .srst(srst), .din(headRaw[g].aboveLow),
        .dout(lowOk[g]));
      lsfac_filt uMid (.clk(clk), .srst(srst), .din(headRaw[g].aboveMid),
        .dout(midOk[g]));
      lsfac_filt uHigh (.clk(clk), .srst(srst), .din(headRaw[g].aboveHigh),
        .dout(highOk[g]));
    end
  endgenerate
  always_ff @(posedge clk) begin
    lowF_r  <= lowOk;
    midF_r  <= midOk;
    highF_r <= highOk;
  end

  assign usable   = ~excluded_r & ~openStringFault & ~shortedStringFault;
  assign anyLow   = |(usable & ~lowF_r);
  assign allMid   = (usable != 3'b000) && ((usable & ~midF_r) == 3'b000);
  assign inWindow = |(usable & lowF_r & ~highF_r);
  assign openNew  = (state_r == LSFAC_ACTIVE && targetCode == CODE_MAX)
                    ? (usable & ~lowF_r) : 3'b000;
  assign shortNew = (state_r == LSFAC_ACTIVE && inWindow)
                    ? (usable & highF_r) : 3'b000;
  assign protFault = inputOvervoltageFault | inputUndervoltageFault
                   | thermalShutdownFault;
  assign longLow  = !enableSupplyInput && enLowCnt_r > 16'(CLR_MAX_CYC);
  assign clrPulse = enableSupplyInput && !enPrev_r
                    && enLowCnt_r >= 16'(CLR_MIN_CYC)
                    && enLowCnt_r <= 16'(CLR_MAX_CYC);

  // enable low-pulse timer
  always_ff @(posedge clk) begin
    if (srst) begin
      enPrev_r   <= 1'b0;
      enLowCnt_r <= 16'h0000;
    end else begin
      enPrev_r <= enableSupplyInput;
      if (enableSupplyInput)
        enLowCnt_r <= 16'h0000;
      else if (enLowCnt_r != 16'hFFFF)
        enLowCnt_r <= enLowCnt_r + 16'h0001;
    end
  end

  // main state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= LSFAC_STANDBY;
      stCnt_r    <= '0;
      excluded_r <= 3'b000;
    end else begin
      stCnt_r <= stCnt_r + 32'd1;
      case (state_r)
        LSFAC_STANDBY: begin
          stCnt_r <= '0;
          if (enableSupplyInput) state_r <= LSFAC_SENSE;
        end
        LSFAC_SENSE: begin
          if (longLow) state_r <= LSFAC_STANDBY;
          else if (protFault) begin
            state_r <= LSFAC_RECOVER;
            stCnt_r <= '0;
          end else if (stCnt_r >= 32'(SENSE_CYC)) begin
            excluded_r <= sinkGrounded;
            state_r    <= LSFAC_ACTIVE;
          end
        end
        LSFAC_ACTIVE: begin
          if (longLow) state_r <= LSFAC_STANDBY;
          else if (protFault) begin
            state_r <= LSFAC_RECOVER;
            stCnt_r <= '0;
          end
        end
        LSFAC_RECOVER: begin
          if (longLow) state_r <= LSFAC_STANDBY;
          else if (stCnt_r >= 32'(RECOVER) && !protRaw.inOver
                   && !protRaw.inUnder && !protRaw.outOver
                   && protRaw.thermClear)
            state_r <= LSFAC_ACTIVE;
        end
        default: state_r <= LSFAC_STANDBY;
      endcase
    end
  end

  // string faults, latched; a detection in the clear cycle still latches
  always_ff @(posedge clk) begin
    if (srst || state_r == LSFAC_STANDBY) begin
      openStringFault    <= 3'b000;
      shortedStringFault <= 3'b000;
    end else begin
      openStringFault    <= (clrPulse ? 3'b000 : openStringFault)
                            | openNew;
      shortedStringFault <= (clrPulse ? 3'b000 : shortedStringFault)
                            | shortNew;
    end
  end

  // adaptive target
  always_ff @(posedge clk) begin
    if (srst || state_r != LSFAC_ACTIVE) begin
      targetCode <= CODE_INIT;
      stepCnt_r  <= '0;
      nudgeCnt_r <= '0;
    end else begin
      stepCnt_r  <= (stepCnt_r >= 32'(STEP - 1)) ? '0 : stepCnt_r + 32'd1;
      nudgeCnt_r <= (nudgeCnt_r >= 32'(NUDGE - 1)) ? '0 : nudgeCnt_r + 32'd1;
      if (stepCnt_r == '0) begin
        if (anyLow) begin
          if (targetCode != CODE_MAX)
            targetCode <= targetCode + 8'h01;
        end else if (allMid || nudgeCnt_r == '0) begin
          if (targetCode != CODE_MIN)
            targetCode <= targetCode - 8'h01;
        end
        // otherwise none below low, not all above mid and no nudge due: hold
      end
    end
  end

  // protection filters
  always_ff @(posedge clk) begin
    if (srst || state_r == LSFAC_STANDBY) begin
      ovoCnt_r <= '0;
      oviCnt_r <= '0;
      thermalShutdownFault   <= 1'b0;
      inputOvervoltageFault  <= 1'b0;
    end else begin
      ovoCnt_r <= protRaw.outOver ? ovoCnt_r + 32'd1 : '0;
      oviCnt_r <= (protRaw.inOver && state_r == LSFAC_ACTIVE)
                  ? oviCnt_r + 32'd1 : '0;
      if (state_r == LSFAC_RECOVER) begin
        inputOvervoltageFault <= 1'b0;
        thermalShutdownFault  <= 1'b0;
      end else begin
        if (ovoCnt_r >= 32'(SHORT_FILT_CYC - 1)
            || oviCnt_r >= 32'((ovpShort_r ? OVP_SHORT : OVP_LONG) - 1))
          inputOvervoltageFault <= 1'b1;
        if (protRaw.thermHot)
          thermalShutdownFault <= 1'b1;
      end
    end
  end

  // undervoltage, every mode
  always_ff @(posedge clk) begin
    if (srst) begin
      uvCnt_r <= '0;
      inputUndervoltageFault <= 1'b0;
    end else begin
      uvCnt_r <= protRaw.inUnder ? uvCnt_r + 32'd1 : '0;
      inputUndervoltageFault <= uvCnt_r >= 32'(SHORT_FILT_CYC - 1)
                                && protRaw.inUnder;
    end
  end

  // shortened ovp filter after an overvoltage fault, restored after long active run
  always_ff @(posedge clk) begin
    if (srst || state_r == LSFAC_STANDBY) begin
      ovpShort_r  <= 1'b0;
      activeCnt_r <= '0;
    end else if (inputOvervoltageFault) begin
      ovpShort_r  <= 1'b1;
      activeCnt_r <= '0;
    end else if (state_r == LSFAC_ACTIVE) begin
      if (activeCnt_r >= 32'(OVP_RESTORE - 1))
        ovpShort_r <= 1'b0;
      else
        activeCnt_r <= activeCnt_r + 32'd1;
    end else
      activeCnt_r <= '0;
  end

  // outputs, registered
  always_ff @(posedge clk) begin
    if (srst) begin
      sinkEnable      <= 3'b000;
      converterEnable <= 1'b0;
      faultOut        <= 1'b0;
      faultOe         <= 1'b0;
    end else begin
      // a fresh protection fault shuts off on the same edge as the state change, not a cycle later
      converterEnable <= !protFault
                         && (state_r == LSFAC_ACTIVE || state_r == LSFAC_SENSE);
      sinkEnable      <= (state_r == LSFAC_ACTIVE && enableSupplyInput
                          && !protFault)
                         ? (usable & {3{pwmIn}}) : 3'b000;
      // open drain: driving low means fault
      faultOe <= protFault || state_r == LSFAC_RECOVER
                 || |openStringFault || |shortedStringFault;
      faultOut <= 1'b0;
    end
  end
endmodule : lsfac_top

// one-flag persistence filter; output follows input once stable FILT_CYC
module lsfac_filt (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  import lsfac_pkg::*;
  logic [7:0] cnt_r;
  logic       last_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r  <= 8'h00;
      last_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      last_r <= din;
      if (din != last_r)
        cnt_r <= 8'h00;
      else if (cnt_r < 8'(FILT_CYC))
        cnt_r <= cnt_r + 8'h01;
      else
        dout <= last_r;
    end
  end
endmodule : lsfac_filt

//--- testbench/lsfac_fault_monitor.sv
/*
  port checks for the led sink fault/adapt controller.
  assumes the 20 MHz clock and sync active-high reset of lsfac_top.
*/
`timescale 1ns/10ps
module lsfac_fault_monitor (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // inputs watched
  input wire logic                  pwmIn,
  input wire lsfac_pkg::lsfac_prot_s protRaw,
  // outputs watched
  input wire logic [2:0]            sinkEnable,
  input wire logic                  converterEnable,
  input wire logic [7:0]            targetCode,
  input wire logic                  faultOut,
  input wire logic                  faultOe,
  input wire logic [2:0]            openStringFault,
  input wire logic [2:0]            shortedStringFault,
  input wire logic                  inputOvervoltageFault,
  input wire logic                  inputUndervoltageFault,
  input wire logic                  thermalShutdownFault
);
  import lsfac_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [11:0] uvCnt_r;
  logic [2:0]  strF;
  logic        anyBad;
  assign strF = openStringFault | shortedStringFault;
  assign anyBad = |{strF, inputOvervoltageFault, inputUndervoltageFault,
                    thermalShutdownFault};
  // saturates so a long undervoltage never wraps back below the limit
  always_ff @(posedge clk) begin
    if (srst || !protRaw.inUnder) uvCnt_r <= 12'h000;
    else if (uvCnt_r != 12'hFFF) uvCnt_r <= uvCnt_r + 12'h001;
  end
  sequence sHeld;
    ($stable(targetCode) || !converterEnable)[*8];
  endsequence
  sequence sAllOff;
    !converterEnable && sinkEnable == 3'h0;
  endsequence
  a_sink_pwm: assert property (sinkEnable != 3'h0 |-> $past(pwmIn))
    else $error("sink enabled without pwm");
  a_pin_low: assert property (!faultOut)
    else $error("fault pin driven high");
  a_bad_sink: assert property ((sinkEnable & strF & $past(strF)) == 3'h0)
    else $error("faulty sink still enabled");
  a_fault_shown: assert property (anyBad |-> ##[0:1] faultOe)
    else $error("fault not indicated");
  a_step_one: assert property (converterEnable && $past(converterEnable)
    && $changed(targetCode) |-> targetCode - $past(targetCode) == 8'h01
    || $past(targetCode) - targetCode == 8'h01)
    else $error("target step not one code");
  a_no_wrap: assert property (converterEnable && $past(converterEnable)
    |-> !($past(targetCode) == 8'hFF && targetCode == 8'h00)
    && !($past(targetCode) == 8'h00 && targetCode == 8'hFF))
    else $error("target code wrapped");
  a_step_gap: assert property (converterEnable && $changed(targetCode)
    |=> sHeld)
    else $error("target steps too close");
  a_off_fault: assert property ($rose(inputUndervoltageFault
    || inputOvervoltageFault || thermalShutdownFault) |-> ##[0:1] sAllOff)
    else $error("outputs on in recovery");
  a_uv_persist: assert property ($rose(inputUndervoltageFault)
    |-> uvCnt_r >= 12'h7CF)
    else $error("undervoltage raised too early");
  a_open_max: assert property ($rose(|openStringFault)
    |-> targetCode == 8'hFF)
    else $error("open fault below max target");
endmodule : lsfac_fault_monitor

bind lsfac_top lsfac_fault_monitor mon (
  .clk(clk), .srst(srst), .pwmIn(pwmIn), .protRaw(protRaw),
  .sinkEnable(sinkEnable), .converterEnable(converterEnable),
  .targetCode(targetCode), .faultOut(faultOut), .faultOe(faultOe),
  .openStringFault(openStringFault),
  .shortedStringFault(shortedStringFault),
  .inputOvervoltageFault(inputOvervoltageFault),
  .inputUndervoltageFault(inputUndervoltageFault),
  .thermalShutdownFault(thermalShutdownFault)
);

//--- testbench/lsfac_host_model.sv
/*
  host pwm source and led string headroom model.
  assumes the 20 MHz clock; pwm runs free at its fastest legal rate.
*/
`timescale 1ns/10ps
module lsfac_host_model #(
  parameter int HALF = 500
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // per sink: 0 below low, 1 window, 2 above mid, 3 above high
  input  wire logic [5:0]            sinkMode,
  // to the block
  output logic                       pwmIn,
  output lsfac_pkg::lsfac_head_s [2:0] headRaw
);
  import lsfac_pkg::*;
  int cnt;
  // 20 kHz is the upper limit and stresses pass-through the most
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 0;
      pwmIn <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pwmIn <= ~pwmIn;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // levels nest, as real comparators on one node must
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      headRaw[i].aboveLow = sinkMode[2*i +: 2] != 2'h0;
      headRaw[i].aboveMid = sinkMode[2*i +: 2] >= 2'h2;
      headRaw[i].aboveHigh = sinkMode[2*i +: 2] == 2'h3;
    end
  end
endmodule : lsfac_host_model

//--- testbench/tb_lsfac_top.sv
/*
  self-checking bench for lsfac_top with shortened protection counts.
  assumes lsfac_pkg, the host model and the bound port monitor.
*/
`timescale 1ns/10ps
module tb_lsfac_top;
  import lsfac_pkg::*;
  logic clk, srst, enableSupplyInput, pwmIn, faultOut, faultOe;
  logic converterEnable, inputOvervoltageFault;
  logic inputUndervoltageFault, thermalShutdownFault;
  logic [2:0] sinkGrounded, sinkEnable, openStringFault, shortedStringFault;
  logic [7:0] targetCode;
  logic [5:0] sinkMode;
  logic [6:0] ev;
  lsfac_head_s [2:0] headRaw;
  lsfac_prot_s protRaw;
  int fail_count = 0;
  int checked = 0;
  int n;
  assign ev = {targetCode != 8'hE0, converterEnable, |openStringFault,
    |shortedStringFault, inputUndervoltageFault, thermalShutdownFault,
    inputOvervoltageFault};
  lsfac_top #(.OVP_LONG(3000), .OVP_SHORT(500), .OVP_RESTORE(1500),
    .RECOVER(1000), .STEP(20)) dut (
    .clk(clk), .srst(srst), .enableSupplyInput(enableSupplyInput),
    .pwmIn(pwmIn), .sinkGrounded(sinkGrounded), .headRaw(headRaw),
    .protRaw(protRaw), .sinkEnable(sinkEnable), .faultOut(faultOut),
    .converterEnable(converterEnable), .targetCode(targetCode),
    .faultOe(faultOe), .openStringFault(openStringFault),
    .shortedStringFault(shortedStringFault),
    .inputOvervoltageFault(inputOvervoltageFault),
    .inputUndervoltageFault(inputUndervoltageFault),
    .thermalShutdownFault(thermalShutdownFault));
  lsfac_host_model host (.clk(clk), .srst(srst), .sinkMode(sinkMode),
    .pwmIn(pwmIn), .headRaw(headRaw));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic waitEv(input int b, input logic lvl, input int lim);
    n = 0;
    while (ev[b] !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : waitEv
  // one high and one low phase, each checked once settled
  task automatic chkSinks(input logic [2:0] mask);
    while (pwmIn !== 1'b1) cyc(1);
    cyc(2);
    check(sinkEnable, mask);
    while (pwmIn !== 1'b0) cyc(1);
    cyc(2);
    check(sinkEnable, 3'h0);
  endtask : chkSinks
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    cyc(60000);
    fail_count++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    enableSupplyInput = 1'b0;
    sinkGrounded = 3'h4;
    sinkMode = 6'h15;
    protRaw = 5'h01;
    cyc(6);
    srst = 1'b0;
    check(targetCode, 8'hE1);
    cyc(50);
    check({faultOe, converterEnable, sinkEnable}, 8'h00);
    enableSupplyInput = 1'b1;
    cyc(202);
    check(converterEnable, 1'b1);
    chkSinks(3'h3);
    cyc(100);
    check(targetCode, 8'hE0);
    waitEv(6, 1'b1, 4000);
    check(n > 1000 && n < 1200, 1'b1);
    check(targetCode, 8'hDF);
    sinkMode = 6'h2A;
    cyc(200);
    check(targetCode <= 8'hD8 && targetCode >= 8'hD4, 1'b1);
    sinkMode = 6'h04;
    waitEv(4, 1'b1, 6000);
    check(openStringFault, 3'h1);
    check(targetCode, 8'hFF);
    cyc(2);
    check({converterEnable, faultOe}, 8'h03);
    chkSinks(3'h2);
    sinkMode = 6'h15;
    cyc(30);
    enableSupplyInput = 1'b0;
    cyc(60);
    check({converterEnable, sinkEnable}, 8'h08);
    cyc(40);
    enableSupplyInput = 1'b1;
    cyc(3);
    check({faultOe, openStringFault}, 8'h00);
    sinkMode = 6'h1D;
    waitEv(3, 1'b1, 500);
    check(shortedStringFault, 3'h2);
    sinkMode = 6'h15;
    enableSupplyInput = 1'b0;
    cyc(600);
    check({converterEnable, faultOe, shortedStringFault}, 8'h00);
    sinkGrounded = 3'h0;
    enableSupplyInput = 1'b1;
    cyc(5);
    check(targetCode, 8'hE1);
    cyc(200);
    chkSinks(3'h7);
    protRaw.inOver = 1'b1;
    waitEv(0, 1'b1, 4000);
    check(n >= 2990 && n < 4000, 1'b1);
    protRaw.inOver = 1'b0;
    waitEv(5, 1'b0, 10);
    waitEv(5, 1'b1, 1200);
    protRaw.inOver = 1'b1;
    waitEv(0, 1'b1, 4000);
    check(n >= 490 && n < 1000, 1'b1);
    protRaw.inOver = 1'b0;
    waitEv(5, 1'b0, 10);
    waitEv(5, 1'b1, 1200);
    protRaw.inUnder = 1'b1;
    waitEv(2, 1'b1, 2500);
    check(n >= 1990 && n < 2500, 1'b1);
    cyc(2);
    check({converterEnable, sinkEnable, faultOe}, 8'h01);
    protRaw.inUnder = 1'b0;
    cyc(900);
    check(converterEnable, 1'b0);
    waitEv(5, 1'b1, 400);
    cyc(2);
    check({converterEnable, faultOe}, 8'h02);
    protRaw = 5'h02;
    waitEv(1, 1'b1, 100);
    check(thermalShutdownFault, 1'b1);
    protRaw = 5'h00;
    cyc(1200);
    check(converterEnable, 1'b0);
    protRaw = 5'h01;
    waitEv(5, 1'b1, 1200);
    check(converterEnable, 1'b1);
    conclude();
  end
endmodule : tb_lsfac_top
